/* hdl/cfpm_counter_pair.sv */
// Counter pair measurement engine with input filters and a result FIFO.
// Assumes terminal inputs are asynchronous and configuration is static
// while a task runs; results are drained through a valid/ready port.
//
// What this block does
// [RULE1] Large range: gate spans programmed input periods
// [RULE2] Large range reports timebase and period counts
// [RULE3] Gate period count is configurable divide ratio
// [RULE4] Pairs are counters 0-1, 2-3, 4-5, 6-7
// [RULE5] Onboard 100 MHz timebase default, selectable terminal; the onboard code here ticks every 40 MHz core cycle
// [RULE6] High frequency: fixed gate, partner counts periods
// [RULE7] Gate duration is configurable measurement time
// [RULE8] Period uses frequency methods, reciprocal result
// [RULE9] Pulse width counts timebase while input active
// [RULE10] Armed during active input: wait next pulse
// [RULE11] Default measures high pulse, rise to fall
// [RULE12] Start edge selectable; opposite edge ends it
// [RULE13] On-demand: measure, hold until read, repeat
// [RULE14] Implicit: every pulse buffered, reads drain buffer
// [RULE15] Sample clock stores latest completed pulse width
// [RULE16] Software start or digital edge arm trigger
// [RULE17] Arm during active input skips that pulse
// [RULE18] Optional glitch filter on each input terminal
// [RULE19] Software should enable sync for shared inputs
// [RULE20] Two-edge: first input edge to second edge
// [RULE21] Eight counters; pairs serve two-counter methods
// [RULE22] 32-bit counts flag overflow on wrap
// [RULE23] Selectors route any terminal or partner output
`timescale 1ns/10ps

module cfpm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = mem[rd_q];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module cfpm_counter_pair #(
  parameter int NUM_TERM      = 16,
  parameter int FIFO_DEPTH    = 32,
  parameter int FILTER_CYCLES = cfpm_pkg::FILTER_CYCLES
) (
  input  wire logic                    I_CORE_CLK,
  input  wire logic                    I_RST,
  input  wire logic [NUM_TERM-1:0]     I_PROGRAMMABLE_FUNCTION_INPUT,
  input  wire logic [NUM_TERM-1:0]     I_FILTER_ENABLE,
  input  wire cfpm_pkg::cfpm_cfg_t     I_CFG,
  input  wire logic                    I_START,
  input  wire logic                    I_STOP,
  output logic                         O_RESULT_VALID,
  input  wire logic                    I_RESULT_READY,
  output cfpm_pkg::cfpm_result_t       O_RESULT,
  output logic                         O_ARMED,
  output logic                         O_MEASURING,
  output logic                         O_PAIR_GATE,
  output logic                         O_OVERRUN
);
  localparam int NSRC = NUM_TERM + 2;
  localparam logic [cfpm_pkg::SEL_W-1:0] SEL_ONBOARD =
    cfpm_pkg::SEL_W'(NUM_TERM + 1);
  localparam int FW = $clog2(FILTER_CYCLES + 1);

  cfpm_pkg::cfpm_state_t  state_q;
  cfpm_pkg::cfpm_result_t pend_q;
  cfpm_pkg::cfpm_result_t new_res;
  cfpm_pkg::cfpm_result_t last_q;

  logic [NUM_TERM-1:0]          filt;
  logic [NSRC-1:0]              src;
  logic [4:0]                   cur;
  logic [4:0]                   prev_q;
  logic [4:0]                   rise;
  logic [4:0]                   fall;
  logic [cfpm_pkg::CNT_W-1:0]   tb_cnt_q;
  logic [cfpm_pkg::CNT_W-1:0]   per_cnt_q;
  logic [cfpm_pkg::CNT_W-1:0]   gate_cnt_q;
  logic [cfpm_pkg::CNT_W-1:0]   tb_next;
  logic [cfpm_pkg::CNT_W-1:0]   per_next;
  logic                         ovf_q;
  logic                         ovf_next;
  logic                         tb_tick;
  logic                         start_hit;
  logic                         done;
  logic                         new_valid;
  logic                         pend_valid_q;
  logic                         last_valid_q;
  logic                         fifo_in_ready;
  logic                         accept;
  logic                         pair_gate_q;
  logic                         overrun_q;
  logic                         is_freq;

  // Out-of-range selector codes read as a quiet low input
  function automatic logic pick(input logic [NSRC-1:0] v,
                                input logic [cfpm_pkg::SEL_W-1:0] s);
    pick = (int'(s) < NSRC) ? v[s] : 1'b0;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_in
      logic [2:0]    sync_q;
      logic          filt_q;
      logic [FW-1:0] fcnt_q;

      always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
          sync_q <= 3'h0;
        end else begin
          sync_q <= {sync_q[1:0], I_PROGRAMMABLE_FUNCTION_INPUT[g]};
        end
      end

      // A change counts once the second and third stages agree, and with the filter on once they stay so for FILTER_CYCLES cycles
      always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
          filt_q <= 1'b0;
          fcnt_q <= '0;
        end else if (sync_q[2] != sync_q[1] || sync_q[1] == filt_q) begin
          fcnt_q <= '0;
        end else if (!I_FILTER_ENABLE[g] ||
                     fcnt_q == FW'(FILTER_CYCLES - 1)) begin  // [RULE18]
          filt_q <= sync_q[1];
          fcnt_q <= '0;
        end else begin
          fcnt_q <= fcnt_q + 1'b1;
        end
      end

      assign filt[g] = filt_q;
    end
  endgenerate

  // Onboard code is held high: the timebase then ticks every core cycle
  assign src = {1'b1, pair_gate_q, filt};                        // [RULE23]

  always_comb begin
    cur[0] = pick(src, (I_CFG.measure_method_select ==
                        cfpm_pkg::MEAS_PULSE_WIDTH)
                       ? I_CFG.width_input_select
                       : I_CFG.freq_input_select);                // [RULE8]
    cur[1] = pick(src, I_CFG.second_input_select);
    cur[2] = pick(src, I_CFG.timebase_select);
    cur[3] = pick(src, I_CFG.sample_clock_select);
    cur[4] = pick(src, I_CFG.arm_trigger_source);
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      prev_q <= 5'h1f;
    end else begin
      prev_q <= cur;
    end
  end

  assign rise = cur & ~prev_q;
  assign fall = ~cur & prev_q;
  assign tb_tick = (I_CFG.timebase_select == SEL_ONBOARD) | rise[2];  // [RULE5]
  assign is_freq = (I_CFG.measure_method_select ==
                    cfpm_pkg::MEAS_LARGE_RANGE) |
                   (I_CFG.measure_method_select == cfpm_pkg::MEAS_HIGH_FREQ);

  // Edge-only start skips a pulse already active when armed
  always_comb begin
    unique case (I_CFG.measure_method_select)
      cfpm_pkg::MEAS_LARGE_RANGE: start_hit = rise[0];
      cfpm_pkg::MEAS_HIGH_FREQ:   start_hit = tb_tick;
      cfpm_pkg::MEAS_PULSE_WIDTH,
      cfpm_pkg::MEAS_TWO_EDGE:    start_hit = I_CFG.pulse_start_edge
                                              ? fall[0] : rise[0]; // [RULE10] [RULE11] [RULE12] [RULE17]
      default:                    start_hit = 1'b0;
    endcase
  end

  assign tb_next  = tb_cnt_q + (tb_tick ? cfpm_pkg::CNT_ONE
                                        : cfpm_pkg::CNT_RST);      // [RULE9]
  assign per_next = per_cnt_q + (rise[0] ? cfpm_pkg::CNT_ONE
                                         : cfpm_pkg::CNT_RST);
  assign ovf_next = ovf_q | (tb_tick & (tb_cnt_q == cfpm_pkg::CNT_MAX))
                  | (rise[0] & (per_cnt_q == cfpm_pkg::CNT_MAX));  // [RULE22]

  always_comb begin
    unique case (I_CFG.measure_method_select)
      cfpm_pkg::MEAS_LARGE_RANGE:
        done = rise[0] & (per_next >= I_CFG.freq_divide_ratio); // [RULE1] [RULE3]
      cfpm_pkg::MEAS_HIGH_FREQ:
        done = tb_tick & (gate_cnt_q <= cfpm_pkg::CNT_ONE);     // [RULE6] [RULE7]
      cfpm_pkg::MEAS_PULSE_WIDTH:
        done = I_CFG.pulse_start_edge ? rise[0] : fall[0];      // [RULE12]
      cfpm_pkg::MEAS_TWO_EDGE:
        done = I_CFG.second_edge ? fall[1] : rise[1];           // [RULE20]
      default:
        done = 1'b0;
    endcase
    done = done & (state_q == cfpm_pkg::ST_MEASURE);
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= cfpm_pkg::ST_IDLE;
    end else if (I_STOP) begin
      state_q <= cfpm_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        cfpm_pkg::ST_IDLE:
          if (I_START) begin
            state_q <= I_CFG.arm_trigger_type ? cfpm_pkg::ST_ARM_WAIT
                                              : cfpm_pkg::ST_WAIT_START; // [RULE16]
          end
        cfpm_pkg::ST_ARM_WAIT:
          if (I_CFG.arm_trigger_edge ? fall[4] : rise[4]) begin  // [RULE16]
            state_q <= cfpm_pkg::ST_WAIT_START;
          end
        cfpm_pkg::ST_WAIT_START:
          if (start_hit) begin
            state_q <= cfpm_pkg::ST_MEASURE;
          end
        cfpm_pkg::ST_MEASURE:
          if (done) begin
            state_q <= (I_CFG.timing == cfpm_pkg::TIM_ON_DEMAND)
                       ? cfpm_pkg::ST_HOLD : cfpm_pkg::ST_WAIT_START;
          end
        cfpm_pkg::ST_HOLD:
          // Input is ignored until the held result has been read out
          if (!pend_valid_q && !O_RESULT_VALID) begin            // [RULE13]
            state_q <= cfpm_pkg::ST_WAIT_START;
          end
        default:
          state_q <= cfpm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tb_cnt_q   <= cfpm_pkg::CNT_RST;
      per_cnt_q  <= cfpm_pkg::CNT_RST;
      gate_cnt_q <= cfpm_pkg::CNT_RST;
      ovf_q      <= 1'b0;
    end else if (state_q == cfpm_pkg::ST_WAIT_START && start_hit) begin
      tb_cnt_q   <= cfpm_pkg::CNT_RST;
      per_cnt_q  <= cfpm_pkg::CNT_RST;
      gate_cnt_q <= I_CFG.gate_measure_time;                    // [RULE7]
      ovf_q      <= 1'b0;
    end else if (state_q == cfpm_pkg::ST_MEASURE) begin
      tb_cnt_q  <= tb_next;
      per_cnt_q <= per_next;
      ovf_q     <= ovf_next;
      if (tb_tick && gate_cnt_q != cfpm_pkg::CNT_RST) begin
        gate_cnt_q <= gate_cnt_q - cfpm_pkg::CNT_ONE;
      end
    end
  end

  // Both counts travel together so software forms fk*T1/T2 or P/T
  always_comb begin
    new_res.timebase_cycle_count = tb_next;                     // [RULE2]
    new_res.input_period_count   = per_next;
    new_res.overflow             = ovf_next;                    // [RULE22]
    new_res.pair                 = I_CFG.pair_select;           // [RULE4]
    new_valid = 1'b0;
    if (I_CFG.timing == cfpm_pkg::TIM_SAMPLE_CLK) begin
      new_valid = rise[3] & last_valid_q &
                  (state_q != cfpm_pkg::ST_IDLE) &
                  (state_q != cfpm_pkg::ST_ARM_WAIT);            // [RULE15]
      new_res   = last_q;
    end else begin
      new_valid = done;                                          // [RULE14]
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      last_q       <= '0;
      last_valid_q <= 1'b0;
    end else if (I_START) begin
      last_valid_q <= 1'b0;
    end else if (done) begin
      last_q       <= new_res;
      last_q.timebase_cycle_count <= tb_next;
      last_q.input_period_count   <= per_next;
      last_q.overflow             <= ovf_next;
      last_q.pair                 <= I_CFG.pair_select;
      last_valid_q <= 1'b1;                                      // [RULE15]
    end
  end

  assign accept = pend_valid_q & fifo_in_ready;

  // A result that finds the staging slot busy is dropped and flagged
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pend_q       <= '0;
      pend_valid_q <= 1'b0;
      overrun_q    <= 1'b0;
    end else begin
      if (new_valid && (!pend_valid_q || accept)) begin
        pend_q       <= new_res;
        pend_valid_q <= 1'b1;
      end else if (accept) begin
        pend_valid_q <= 1'b0;
      end
      if (new_valid && pend_valid_q && !accept) begin
        overrun_q <= 1'b1;
      end else if (I_START) begin
        overrun_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pair_gate_q <= 1'b0;
    end else begin
      pair_gate_q <= is_freq & (state_q == cfpm_pkg::ST_MEASURE); // [RULE21]
    end
  end

  cfpm_fifo #(
    .WIDTH ($bits(cfpm_pkg::cfpm_result_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CORE_CLK),
    .i_rst       (I_RST),
    .i_in_valid  (pend_valid_q),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (pend_q),
    .o_out_valid (O_RESULT_VALID),
    .i_out_ready (I_RESULT_READY),
    .o_out_data  (O_RESULT)
  );

  assign O_ARMED     = (state_q == cfpm_pkg::ST_WAIT_START) |
                       (state_q == cfpm_pkg::ST_MEASURE);
  assign O_MEASURING = (state_q == cfpm_pkg::ST_MEASURE);
  assign O_PAIR_GATE = pair_gate_q;
  assign O_OVERRUN   = overrun_q;

endmodule

/* hdl/cfpm_pkg.sv */
// Constants, modes and carriers of the counter pair measurement block.
// Assumes the core clock runs at 40 MHz and software drives configuration.
package cfpm_pkg;

  localparam int CNT_W        = 32;
  localparam int SEL_W        = 5;
  localparam int PAIR_W       = 2;
  localparam int NUM_COUNTERS = 8;
  localparam int NUM_PAIRS    = NUM_COUNTERS / 2;

  localparam int CORE_CLK_MHZ   = 40;
  localparam int ONBOARD_TB_MHZ = 100;
  // Least time an input must stay steady before the filter passes it
  localparam int FILTER_TIME_NS = 125;
  localparam int FILTER_CYCLES  = (FILTER_TIME_NS * CORE_CLK_MHZ + 999) / 1000;

  localparam logic [CNT_W-1:0] CNT_RST   = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_MAX   = 32'hffff_ffff;
  localparam logic [CNT_W-1:0] CNT_ONE   = 32'h0000_0001;

  typedef enum logic [3:0] {
    MEAS_LARGE_RANGE = 4'h1,
    MEAS_HIGH_FREQ   = 4'h2,
    MEAS_PULSE_WIDTH = 4'h4,
    MEAS_TWO_EDGE    = 4'h8
  } cfpm_method_t;

  typedef enum logic [1:0] {
    TIM_ON_DEMAND  = 2'h0,
    TIM_IMPLICIT   = 2'h1,
    TIM_SAMPLE_CLK = 2'h2
  } cfpm_timing_t;

  typedef enum logic [4:0] {
    ST_IDLE       = 5'h01,
    ST_ARM_WAIT   = 5'h02,
    ST_WAIT_START = 5'h04,
    ST_MEASURE    = 5'h08,
    ST_HOLD       = 5'h10
  } cfpm_state_t;

  typedef struct packed {
    cfpm_method_t       measure_method_select;
    cfpm_timing_t       timing;
    logic [SEL_W-1:0]   freq_input_select;
    logic [SEL_W-1:0]   width_input_select;
    logic [SEL_W-1:0]   second_input_select;
    logic [SEL_W-1:0]   timebase_select;
    logic [SEL_W-1:0]   sample_clock_select;
    logic [CNT_W-1:0]   freq_divide_ratio;
    logic [CNT_W-1:0]   gate_measure_time;
    logic               pulse_start_edge;
    logic               second_edge;
    logic               arm_trigger_type;
    logic [SEL_W-1:0]   arm_trigger_source;
    logic               arm_trigger_edge;
    logic [PAIR_W-1:0]  pair_select;
  } cfpm_cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0]  timebase_cycle_count;
    logic [CNT_W-1:0]  input_period_count;
    logic              overflow;
    logic [PAIR_W-1:0] pair;
  } cfpm_result_t;

endpackage

/* bench/cfpm_chk_assertions.sv */
// Port checks of the counter pair measurement block.
// Bound to every cfpm_counter_pair; one core clock domain.
`timescale 1ns/10ps

module cfpm_chk (
  input wire logic                   I_CORE_CLK,
  input wire logic                   I_RST,
  input wire cfpm_pkg::cfpm_cfg_t    I_CFG,
  input wire logic                   I_START,
  input wire logic                   I_STOP,
  input wire logic                   O_RESULT_VALID,
  input wire logic                   I_RESULT_READY,
  input wire cfpm_pkg::cfpm_result_t O_RESULT,
  input wire logic                   O_ARMED,
  input wire logic                   O_MEASURING,
  input wire logic                   O_PAIR_GATE,
  input wire logic                   O_OVERRUN
);
  logic idle_q;
  logic freq_m;
  logic od_w;

  assign freq_m = I_CFG.measure_method_select == cfpm_pkg::MEAS_LARGE_RANGE ||
                  I_CFG.measure_method_select == cfpm_pkg::MEAS_HIGH_FREQ;
  assign od_w = I_CFG.measure_method_select == cfpm_pkg::MEAS_PULSE_WIDTH &&
                I_CFG.timing == cfpm_pkg::TIM_ON_DEMAND;

  // Tracks the idle state, which no output shows on its own
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      idle_q <= 1'h1;
    end else if (I_STOP) begin
      idle_q <= 1'h1;
    end else if (I_START) begin
      idle_q <= 1'h0;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence width_done_s;
    od_w && O_MEASURING && !I_STOP ##1 !O_MEASURING;
  endsequence
  sequence soft_start_s;
    idle_q && I_START && !I_STOP;
  endsequence

  result_latency_a: assert property (width_done_s |-> ##[1:3] O_RESULT_VALID)
    else $error("width result did not reach the output");
  hold_ignore_a: assert property (od_w && O_RESULT_VALID |-> !O_MEASURING)
    else $error("measuring while a result is held");
  soft_arm_a: assert property (soft_start_s and !I_CFG.arm_trigger_type |=> O_ARMED)
    else $error("start did not arm the counter");
  trig_wait_a: assert property (soft_start_s and I_CFG.arm_trigger_type |=> !O_ARMED)
    else $error("armed before the trigger edge");
  stop_idle_a: assert property (I_STOP |=> !O_ARMED && !O_MEASURING)
    else $error("stop did not force idle");
  measure_armed_a: assert property (O_MEASURING |-> O_ARMED)
    else $error("measuring while not armed");
  gate_start_a: assert property (freq_m && $rose(O_MEASURING) |=> O_PAIR_GATE)
    else $error("gate missing after measure start");
  gate_method_a: assert property (O_PAIR_GATE |-> freq_m)
    else $error("gate outside frequency methods");
  pair_label_a: assert property (O_RESULT_VALID |-> O_RESULT.pair == I_CFG.pair_select)
    else $error("result carries wrong pair");
  result_hold_a: assert property (O_RESULT_VALID && !I_RESULT_READY |=>
    O_RESULT_VALID && $stable(O_RESULT))
    else $error("result changed before it was read");
  overrun_keep_a: assert property (O_OVERRUN && !I_START && !I_STOP |=> O_OVERRUN)
    else $error("overrun flag cleared on its own");
endmodule

bind cfpm_counter_pair cfpm_chk i_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_CFG(I_CFG), .I_START(I_START),
  .I_STOP(I_STOP), .O_RESULT_VALID(O_RESULT_VALID),
  .I_RESULT_READY(I_RESULT_READY), .O_RESULT(O_RESULT), .O_ARMED(O_ARMED),
  .O_MEASURING(O_MEASURING), .O_PAIR_GATE(O_PAIR_GATE),
  .O_OVERRUN(O_OVERRUN)
);

/* bench/cfpm_sig_model.sv */
// Signal sources wired to the terminals of the counter pair block.
// Shares the core clock and changes pins only on falling edges.
`timescale 1ns/10ps

module cfpm_sig_model (
  input  wire logic  i_clk,
  output logic [15:0] o_pins
);
  initial o_pins = 16'h0;

  task automatic set_pin(input int idx, input logic val);
    @(negedge i_clk);
    o_pins[idx] = val;
  endtask

  // Level val for hi cycles, then its inverse for lo cycles
  task automatic pulse(input int idx, input logic val, input int hi,
                       input int lo);
    set_pin(idx, val);
    repeat (hi - 1) @(negedge i_clk);
    set_pin(idx, !val);
    repeat (lo - 1) @(negedge i_clk);
  endtask
endmodule

/* bench/cfpm_counter_pair_test.sv */
// Bench for the counter pair block: scenarios, watchdog and verdict.
// Assumes selector 5'h11 is the onboard timebase ticking every core clock.
`timescale 1ns/10ps

module cfpm_counter_pair_test;
  logic                   clk, rst, start, stop, res_ready;
  logic                   res_valid, armed, measuring, gate, overrun;
  logic [15:0]            pins;
  logic [15:0]            filt_en;
  cfpm_pkg::cfpm_cfg_t    cfg;
  cfpm_pkg::cfpm_result_t res;
  int                     err_count;
  int                     samples_checked;

  cfpm_sig_model i_src (.i_clk(clk), .o_pins(pins));

  cfpm_counter_pair #(.NUM_TERM(16), .FIFO_DEPTH(32), .FILTER_CYCLES(2))
  i_dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_PROGRAMMABLE_FUNCTION_INPUT(pins),
    .I_FILTER_ENABLE(filt_en), .I_CFG(cfg), .I_START(start), .I_STOP(stop),
    .O_RESULT_VALID(res_valid), .I_RESULT_READY(res_ready), .O_RESULT(res),
    .O_ARMED(armed), .O_MEASURING(measuring), .O_PAIR_GATE(gate),
    .O_OVERRUN(overrun)
  );

  always #12.5 clk = ~clk;

  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Waits for a result, judges the selected counts and reads it out
  task automatic pop(input logic [31:0] tb, input logic [31:0] per,
                     input logic [1:0] what);
    int n;
    n = 0;
    while (res_valid !== 1'h1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("result_valid", 32'h1, {31'h0, res_valid});
    if (what[0]) check("tb_count", tb, res.timebase_cycle_count);
    if (what[1]) check("period_count", per, res.input_period_count);
    check("overflow", 32'h0, {31'h0, res.overflow});
    check("pair", 32'h2, {30'h0, res.pair});
    res_ready = 1'h1;
    @(negedge clk);
    res_ready = 1'h0;
    // Let an edge pass so a following pop never re-raises ready at once
    @(negedge clk);
  endtask

  task automatic noval(input int n);
    repeat (n) @(negedge clk);
    check("no_result", 32'h0, {31'h0, res_valid});
  endtask

  // Config only changes while stop holds the engine idle
  task automatic go(input cfpm_pkg::cfpm_cfg_t c);
    @(negedge clk);
    stop = 1'h1;
    // Two idle edges first, so the registered pair gate has dropped
    repeat (2) @(negedge clk);
    cfg = c;
    @(negedge clk);
    stop = 1'h0;
    start = 1'h1;
    @(negedge clk);
    start = 1'h0;
  endtask

  function automatic cfpm_pkg::cfpm_cfg_t base();
    cfpm_pkg::cfpm_cfg_t c;
    c = '0;
    c.measure_method_select = cfpm_pkg::MEAS_PULSE_WIDTH;
    c.timing = cfpm_pkg::TIM_ON_DEMAND;
    c.second_input_select = 5'h3;
    c.timebase_select = 5'h11;
    c.sample_clock_select = 5'h2;
    c.arm_trigger_source = 5'h1;
    c.freq_divide_ratio = 32'h3;
    c.gate_measure_time = 32'h14;
    c.pair_select = 2'h2;
    return c;
  endfunction

  task automatic t_on_demand();
    i_src.set_pin(0, 1'h1);
    go(base());
    check("armed", 32'h1, {31'h0, armed});
    i_src.pulse(0, 1'h0, 4, 7);
    i_src.pulse(0, 1'h0, 4, 4);
    pop(32'h7, 32'h0, 2'h1);
    // Input went high while held, so the next full pulse is measured
    i_src.pulse(0, 1'h0, 2, 5);
    i_src.set_pin(0, 1'h0);
    pop(32'h5, 32'h0, 2'h1);
  endtask

  task automatic t_falling();
    cfpm_pkg::cfpm_cfg_t c;
    c = base();
    c.pulse_start_edge = 1'h1;
    i_src.set_pin(0, 1'h1);
    go(c);
    i_src.pulse(0, 1'h0, 9, 4);
    pop(32'h9, 32'h0, 2'h1);
    go(base());
    i_src.set_pin(0, 1'h0);
    noval(6);
  endtask

  task automatic t_fill();
    cfpm_pkg::cfpm_cfg_t c;
    c = base();
    c.timing = cfpm_pkg::TIM_IMPLICIT;
    go(c);
    for (int k = 0; k < 34; k++) i_src.pulse(0, 1'h1, 2 + k % 4, 3);
    // The last falling edge needs a few cycles through the synchroniser
    repeat (4) @(negedge clk);
    check("result_valid", 32'h1, {31'h0, res_valid});
    check("overrun", 32'h1, {31'h0, overrun});
    for (int k = 0; k < 33; k++) pop(2 + k % 4, 32'h0, 2'h1);
    noval(4);
    go(c);
    check("overrun", 32'h0, {31'h0, overrun});
  endtask

  task automatic t_sample();
    cfpm_pkg::cfpm_cfg_t c;
    c = base();
    c.timing = cfpm_pkg::TIM_SAMPLE_CLK;
    go(c);
    i_src.pulse(2, 1'h1, 2, 4);
    noval(6);
    i_src.pulse(0, 1'h1, 4, 3);
    i_src.pulse(0, 1'h1, 6, 3);
    i_src.pulse(2, 1'h1, 2, 4);
    pop(32'h6, 32'h0, 2'h1);
    noval(8);
  endtask

  task automatic t_arm();
    cfpm_pkg::cfpm_cfg_t c;
    for (int e = 0; e < 2; e++) begin
      c = base();
      c.arm_trigger_type = 1'h1;
      c.arm_trigger_edge = e[0];
      i_src.set_pin(1, e[0]);
      go(c);
      i_src.pulse(0, 1'h1, 3, 4);
      noval(4);
      i_src.set_pin(0, 1'h1);
      i_src.pulse(1, !e[0], 2, 3);
      i_src.pulse(0, 1'h0, 3, 5);
      i_src.pulse(0, 1'h0, 4, 2);
      pop(32'h5, 32'h0, 2'h1);
      i_src.set_pin(1, 1'h0);
    end
  endtask

  task automatic t_freq();
    cfpm_pkg::cfpm_cfg_t c;
    c = base();
    c.measure_method_select = cfpm_pkg::MEAS_LARGE_RANGE;
    c.timing = cfpm_pkg::TIM_IMPLICIT;
    go(c);
    repeat (5) i_src.pulse(0, 1'h1, 3, 3);
    pop(32'h12, 32'h3, 2'h3);
    c.measure_method_select = cfpm_pkg::MEAS_HIGH_FREQ;
    c.timing = cfpm_pkg::TIM_ON_DEMAND;
    fork
      repeat (12) i_src.pulse(0, 1'h1, 2, 2);
      go(c);
    join
    pop(32'h0, 32'h5, 2'h2);
  endtask

  task automatic t_two_edge();
    cfpm_pkg::cfpm_cfg_t c;
    c = base();
    c.measure_method_select = cfpm_pkg::MEAS_TWO_EDGE;
    c.second_edge = 1'h1;
    i_src.set_pin(3, 1'h1);
    go(c);
    i_src.set_pin(0, 1'h1);
    repeat (7) @(negedge clk);
    i_src.set_pin(3, 1'h0);
    i_src.set_pin(0, 1'h0);
    pop(32'h8, 32'h0, 2'h1);
  endtask

  task automatic t_filter();
    cfpm_pkg::cfpm_cfg_t c;
    c = base();
    c.timing = cfpm_pkg::TIM_IMPLICIT;
    // Each terminal feeds one selector, so sync is not needed
    filt_en = 16'h0001;
    go(c);
    // Two cycles pass the synchroniser but not the enabled filter
    i_src.pulse(0, 1'h1, 2, 8);
    noval(4);
    i_src.pulse(0, 1'h1, 6, 8);
    pop(32'h6, 32'h0, 2'h1);
    filt_en = 16'h0;
  endtask

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    start = 1'h0;
    stop = 1'h0;
    res_ready = 1'h0;
    filt_en = 16'h0;
    cfg = base();
    err_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    t_on_demand();
    t_falling();
    t_fill();
    t_sample();
    t_arm();
    t_freq();
    t_two_edge();
    t_filter();
    print_verdict();
  end

  // Whole run needs about 700 cycles
  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
